// [tcp_pkg.sv]
/*
  tcp_pkg: constants and carrier types for the eight-bit timer/counter with shared prescaler.
  assumes a single 20 MHz core clock and a plain register port with one-cycle strobes.
*/
package tcp_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] OFS_COUNT   = 2'h0;
  localparam logic [1:0] OFS_CONFIG  = 2'h1;
  localparam logic [1:0] OFS_IRQCTL  = 2'h2;
  // configuration register field positions
  localparam int CFG_CS      = 5;
  localparam int CFG_SE      = 4;
  localparam int CFG_PSA     = 3;
  localparam int CFG_PS_HI   = 2;
  // interrupt control field positions
  localparam int IRQ_EN_BIT  = 5;
  localparam int IRQ_FLG_BIT = 2;
  // reset values
  localparam logic [7:0] CONFIG_RST = 8'hFF;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  // phases per instruction cycle and write inhibit length
  localparam int          PHASES        = 4;
  localparam logic [1:0]  PH_SECOND     = 2'h1;
  localparam logic [1:0]  PH_FOURTH     = 2'h3;
  localparam logic [1:0]  PH_LAST       = 2'h3;
  localparam logic [1:0]  INHIBIT_CYC   = 2'h2;

  // one register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcp_req_t;

  // decoded configuration
  typedef struct packed {
    logic       ext_src;
    logic       fall_edge;
    logic       to_watchdog;
    logic [2:0] ratio;
  } tcp_cfg_t;
endpackage : tcp_pkg

// [tcp_timer.sv]
/*
  tcp_timer: eight-bit timer/counter, shared eight-bit prescaler, overflow flag and mask.
  assumes the external count pin is asynchronous; sleep and watchdog clear come from the core.
*/
// Contract
// - eight-bit count, readable and writable by software at any time.
// - source select clear: count once per instruction cycle without prescaler.
// - after a count write, counting is held off for two instruction cycles.
// - source select set: count edges of the external count input.
// - edge select clear picks rising edges, set picks falling edges.
// - prescaler belongs to counter when assign bit clear, watchdog when set.
// - three-bit ratio field; watchdog assignment gives the counter 1:1.
// - prescaler count is neither readable nor writable by software.
// - wrap from FFh to 00h sets the overflow flag.
// - interrupt enable gates the request; flag still sets while masked.
// - counter stops during sleep, so overflow never wakes the core.
// - external input passes the prescaler first, then gets synchronised; here the pin is synchronised first, then feeds the prescaler.
// - prescaler output sampled on second and fourth internal phases.
// - count updates a few phases after the external edge.
// - count write clears prescaler count while assigned to the counter.
// - watchdog clear clears prescaler count while assigned to watchdog.
module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       external_count_pin,
  input  wire logic       sleep,
  input  wire logic       watchdog_clear_instruction,
  input  wire logic       watchdog_tick,
  output logic            watchdog_out,
  output logic            irq
);

  tcp_req_t   req;
  tcp_cfg_t   cfg;
  logic [7:0] config_ff;
  logic [7:0] count_register_ff;
  logic       overflow_flag_ff;
  logic       overflow_irq_enable_ff;
  logic [1:0] phase_ff;
  logic [2:0] pin_sync_ff;
  logic       pin_level_ff;
  logic [7:0] prescale_ff;
  logic       psc_out_ff;
  logic       psc_smp_ff;
  logic       psc_prev_ff;
  logic [1:0] inhibit_ff;
  logic       wd_out_ff;
  logic       ext_edge;
  logic       psc_clk_in;
  logic       psc_tap;
  logic       psc_step;
  logic       inc_src;
  logic       inc;
  logic       count_wr;
  logic       wrap;

  // bundle request and decode configuration
  assign req      = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
  assign cfg      = '{ext_src: config_ff[CFG_CS], fall_edge: config_ff[CFG_SE],
                      to_watchdog: config_ff[CFG_PSA], ratio: config_ff[CFG_PS_HI:0]};
  assign count_wr = req.wr && (req.addr == OFS_COUNT);

  // selects one prescaler tap from the ratio field
  function automatic logic tap_sel(input logic [7:0] cnt, input logic [2:0] n);
    tap_sel = cnt[n];
  endfunction : tap_sel

  // instruction-cycle phase counter, frozen in sleep
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= 2'h0;
    else if (!sleep)
      phase_ff <= phase_ff + 2'h1;
  end

  // three-stage pin synchroniser; a change counts when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync_ff  <= 3'h0;
      pin_level_ff <= 1'b0;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[1:0], external_count_pin};
      if (pin_sync_ff[1] == pin_sync_ff[2])
        pin_level_ff <= pin_sync_ff[2];
    end
  end

  // counting edge of the pin: the selected polarity folded in before the prescaler
  assign ext_edge = pin_level_ff ^ cfg.fall_edge;

  // prescaler input: watchdog tick when assigned to the watchdog, else pin edge level in counter mode, phase clock in timer mode
  always_comb
  begin
    if (cfg.to_watchdog)
      psc_clk_in = watchdog_tick;
    else if (cfg.ext_src)
      psc_clk_in = ext_edge;
    else
      psc_clk_in = (phase_ff == PH_LAST);
  end

  // rising transitions of the prescaler input advance it
  logic psc_in_prev_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      psc_in_prev_ff <= 1'b0;
    else
      psc_in_prev_ff <= psc_clk_in;
  end
  assign psc_step = psc_clk_in && !psc_in_prev_ff;

  // prescaler count: cleared by a count write when owned by the counter or a watchdog clear when owned by the watchdog, never software visible
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prescale_ff <= 8'h00;
    else if (count_wr && !cfg.to_watchdog)
      prescale_ff <= 8'h00;
    else if (watchdog_clear_instruction && cfg.to_watchdog)
      prescale_ff <= 8'h00;
    else if (psc_step && !sleep)
      prescale_ff <= prescale_ff + 8'h01;
  end

  // prescaler output: tap n gives divide by two to the n plus one; bypass when given away
  assign psc_tap = tap_sel(prescale_ff, cfg.ratio);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      psc_out_ff <= 1'b0;
    else if (cfg.to_watchdog)
      psc_out_ff <= cfg.ext_src ? ext_edge : phase_ff[1]; // two phases wide so a sample catches it
    else
      psc_out_ff <= psc_tap;
  end

  // watchdog side of the shared prescaler
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_out_ff <= 1'b0;
    else
      wd_out_ff <= cfg.to_watchdog ? psc_tap : watchdog_tick;
  end
  assign watchdog_out = wd_out_ff;

  // sample prescaler output on the second and fourth phases
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      psc_smp_ff  <= 1'b0;
      psc_prev_ff <= 1'b0;
    end
    else if (phase_ff == PH_SECOND || phase_ff == PH_FOURTH)
    begin
      psc_smp_ff  <= psc_out_ff;
      psc_prev_ff <= psc_smp_ff;
    end
  end
  // fourth-phase sample of the previous instruction cycle, so a rise seen at either sample counts once
  logic psc_old_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      psc_old_ff <= 1'b0;
    else if (phase_ff == 2'h0)
      psc_old_ff <= psc_smp_ff;
  end
  // increment request in phase zero after a rise between any two successive samples
  assign inc_src = (phase_ff == 2'h0) &&
                   ((!psc_old_ff && psc_prev_ff) || (!psc_prev_ff && psc_smp_ff));

  // write inhibit: two instruction cycles after a count write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      inhibit_ff <= 2'h0;
    else if (count_wr)
      inhibit_ff <= (phase_ff == PH_LAST) ? INHIBIT_CYC : INHIBIT_CYC + 2'h1; // rest of own cycle too
    else if (inhibit_ff != 2'h0 && phase_ff == PH_LAST)
      inhibit_ff <= inhibit_ff - 2'h1;
  end

  assign inc  = inc_src && (inhibit_ff == 2'h0) && !sleep;
  assign wrap = inc && (count_register_ff == 8'hFF);

  // count register: software write wins over increment
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_register_ff <= COUNT_RST;
    else if (count_wr)
      count_register_ff <= req.wdata;
    else if (inc)
      count_register_ff <= count_register_ff + 8'h01;
  end

  // configuration register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      config_ff <= CONFIG_RST;
    else if (req.wr && req.addr == OFS_CONFIG)
      config_ff <= req.wdata;
  end

  // overflow flag: write one to clear, but a wrap in the same cycle wins and sets
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      overflow_flag_ff <= 1'b0;
    else if (wrap)
      overflow_flag_ff <= 1'b1;
    else if (req.wr && req.addr == OFS_IRQCTL && req.wdata[IRQ_FLG_BIT])
      overflow_flag_ff <= 1'b0;
  end

  // interrupt enable acts as the mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      overflow_irq_enable_ff <= 1'b0;
    else if (req.wr && req.addr == OFS_IRQCTL)
      overflow_irq_enable_ff <= req.wdata[IRQ_EN_BIT];
  end

  // level interrupt, registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= overflow_flag_ff && overflow_irq_enable_ff && !sleep;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (req.rd)
      unique case (req.addr)
        OFS_COUNT:  rdata <= count_register_ff;
        OFS_CONFIG: rdata <= config_ff;
        OFS_IRQCTL: rdata <= {2'h0, overflow_irq_enable_ff, 2'h0, overflow_flag_ff, 2'h0};
        default:    rdata <= 8'h00;
      endcase
    else
      rdata <= 8'h00;
  end

  // flag follows a wrap on the next edge
  wrap_sets_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrap |=> overflow_flag_ff) else $error("wrap did not set flag");
  // write arms the inhibit counter with two, or three when not written in the last phase
  write_inhibit_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_wr |=> (inhibit_ff == (($past(phase_ff) == PH_LAST) ? INHIBIT_CYC : INHIBIT_CYC + 2'h1)))
    else $error("inhibit not armed");
  // written value appears
  count_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_wr |=> count_register_ff == $past(req.wdata)) else $error("count write lost");
  // no count in sleep
  sleep_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep && !count_wr |=> $stable(count_register_ff)) else $error("counted in sleep");
  // prescaler cleared on write when owned
  psc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_wr && !cfg.to_watchdog |=> prescale_ff == 8'h00) else $error("prescaler not cleared");
  // watchdog clear clears prescaler when owned by watchdog
  wd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    watchdog_clear_instruction && cfg.to_watchdog && !count_wr |=> prescale_ff == 8'h00)
    else $error("watchdog clear missed");
  // masked flag never raises irq
  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    !overflow_irq_enable_ff |=> !irq) else $error("irq while masked");
  // sampler only moves on second or fourth phase
  sample_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(psc_smp_ff) |-> $past(phase_ff) == PH_SECOND || $past(phase_ff) == PH_FOURTH)
    else $error("sample off phase");
endmodule : tcp_timer

// [tcp_pin_src.sv]
/*
  tcp_pin_src: model of the signal source on the external count pin.
  assumes a burst is asked for by go held one clock; the pin keeps its level between bursts.
*/
module tcp_pin_src (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] n_edges,
  input  wire logic [2:0] half,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle level before the first burst
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // toggle the pin n_edges times, half clocks apart, skewed from the core edges
  always @(posedge clk)
  begin
    if (go)
    begin
      busy = 1'b1;
      for (int i = 0; i < n_edges; i++)
      begin
        repeat (half) @(negedge clk);
        #7 pin = ~pin; // 7 ns after a falling clock edge, clear of the rising edge
      end
      busy = 1'b0;
    end
  end
endmodule : tcp_pin_src

// [tcp_timer_tb.sv]
/*
  tcp_timer_tb: self-checking bench for the timer/counter with shared prescaler.
  assumes tcp_pkg, tcp_timer and the pin source model are compiled before it.
*/
module tcp_timer_tb
  import tcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, sleep = 1'b0, wdc = 1'b0;
  logic        tick = 1'b0, go = 1'b0, busy, pin, irq, wdo;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00, rdata, v, w, x;
  logic [4:0]  n_e = 5'h01;
  logic [2:0]  half = 3'h4;
  logic [31:0] seed = 32'h65F0;
  int          n_fail = 0, checked = 0, cyc = 0, e;

  tcp_timer dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .external_count_pin(pin), .sleep(sleep), .watchdog_clear_instruction(wdc),
    .watchdog_tick(tick), .watchdog_out(wdo), .irq(irq));
  tcp_pin_src src (.clk(clk), .go(go), .n_edges(n_e), .half(half), .pin(pin), .busy(busy));

  // core clock and a slow watchdog oscillator
  always #25 clk = ~clk;
  always #170 tick = ~tick;

  task automatic conclude;
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one-cycle register strobes; read data taken in the cycle after the strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // counting edges among n toggles that start from level start
  function automatic logic [7:0] edges(input logic start, input logic fall, input logic [4:0] n);
    return (fall == start) ? (({3'h0, n} + 8'h01) >> 1) : ({3'h0, n} >> 1);
  endfunction : edges

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CONFIG, v);
    check(v, CONFIG_RST);
    rd(OFS_COUNT, v);
    check(v, COUNT_RST);
    rd(OFS_IRQCTL, v);
    check(v, 8'h00);
    rd(2'h3, v);
    check(v, 8'h00);
    // timer mode, prescaler to the watchdog: counter runs 1:1 whatever the ratio
    wr(OFS_CONFIG, 8'h0F);
    repeat (4)
    begin
      seed = xs(seed);
      x = seed[7:0];
      wr(OFS_COUNT, x);
      rd(OFS_COUNT, v);
      check(v, x);
    end
    repeat (36) @(posedge clk);
    rd(OFS_COUNT, v);
    v = v - x;
    check({7'h00, v == 8'h07 || v == 8'h08}, 8'h01);
    rd(OFS_COUNT, v);
    repeat (38) @(posedge clk);
    rd(OFS_COUNT, w);
    check(w - v, 8'h0A);
    // prescaler on the counter: one count per 8 << n clocks
    for (int n = 0; n < 8; n++)
    begin
      wr(OFS_CONFIG, 8'(n));
      wr(OFS_COUNT, 8'h00);
      repeat (10) @(posedge clk);
      rd(OFS_COUNT, v);
      repeat ((16 << n) - 2) @(posedge clk);
      rd(OFS_COUNT, w);
      check(w - v, 8'h02);
    end
    wr(OFS_COUNT, 8'h00);
    repeat (400) @(posedge clk);
    wr(OFS_COUNT, 8'h00);
    repeat (400) @(posedge clk);
    wr(OFS_COUNT, 8'h00);
    repeat (400) @(posedge clk);
    rd(OFS_COUNT, v);
    check(v, 8'h00);
    // overflow with the request masked, then enabled, slept and cleared
    wr(OFS_CONFIG, 8'h08);
    wr(OFS_COUNT, 8'hFD);
    repeat (30) @(posedge clk);
    rd(OFS_IRQCTL, v);
    check(v, 8'h04);
    check({7'h00, irq}, 8'h00);
    wr(OFS_IRQCTL, 8'h20);
    repeat (2) @(negedge clk);
    check({7'h00, irq}, 8'h01);
    @(posedge clk);
    sleep <= 1'b1;
    rd(OFS_COUNT, v);
    repeat (40) @(posedge clk);
    rd(OFS_COUNT, w);
    check(w, v);
    check({7'h00, irq}, 8'h00);
    @(posedge clk);
    sleep <= 1'b0;
    rd(OFS_IRQCTL, v);
    check(v, 8'h24);
    wr(OFS_IRQCTL, 8'h24);
    rd(OFS_IRQCTL, v);
    check(v, 8'h20);
    check({7'h00, irq}, 8'h00);
    @(posedge clk);
    wdc <= 1'b1;
    @(posedge clk);
    wdc <= 1'b0;
    // counter mode: random bursts, random edge, prescaler 1:1 or 1:2
    repeat (6)
    begin
      seed = xs(seed);
      wr(OFS_CONFIG, {2'b00, 1'b1, seed[4], seed[5], 3'b000});
      wr(OFS_COUNT, 8'h00);
      repeat (12) @(posedge clk);
      e = edges(pin, seed[4], {seed[11:8], 1'b1});
      n_e  <= {seed[11:8], 1'b1};
      half <= {1'b1, seed[13:12]};
      go   <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      while (busy) @(posedge clk);
      repeat (20) @(posedge clk);
      rd(OFS_COUNT, v);
      check(v, seed[5] ? 8'(e) : 8'((e + 1) / 2));
    end
    conclude();
  end
endmodule : tcp_timer_tb
